// ===== verilog/fxr_pkg.sv
// Shared constants and types for the extended read register block.
// Assumes one 100 MHz clock shared by both ends of the link.
package fxr_pkg;
	////////////////////////////////////////////////////////////////
	// Widths
	localparam int DATA_W = 8;
	localparam int DRV_W = 3;
	localparam int ERR_W = 3;
	localparam int CNT_W = 4;

	////////////////////////////////////////////////////////////////
	// Register field positions
	localparam int EXT_BUSY = 0;
	localparam int EXT_ERR_LO = 1;
	localparam int EXT_ERR_HI = 3;
	localparam int EXT_LPE = 4;
	localparam int EXT_DRV_LO = 5;
	localparam int EXT_DRV_HI = 7;
	// Positions inside the error field
	localparam int ERR_X = 0;
	localparam int ERR_P = 1;
	localparam int ERR_E = 2;

	////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] OP_FAST_RD = 8'h0B;
	localparam logic [7:0] OP_FAST_RD4 = 8'h0C;
	localparam logic [7:0] OP_DTR_RD = 8'h0D;
	localparam logic [7:0] OP_DTR_RD4 = 8'h0E;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_OUT4 = 8'h3C;
	localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
	localparam logic [7:0] OP_QUAD_OUT4 = 8'h6C;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam logic [7:0] OP_DUAL_IO4 = 8'hBC;
	localparam logic [7:0] OP_DUAL_IO_DTR = 8'hBD;
	localparam logic [7:0] OP_DUAL_IO_DTR4 = 8'hBE;
	localparam logic [7:0] OP_QUAD_IO = 8'hEB;
	localparam logic [7:0] OP_QUAD_IO4 = 8'hEC;
	localparam logic [7:0] OP_QUAD_IO_DTR = 8'hED;
	localparam logic [7:0] OP_QUAD_IO_DTR4 = 8'hEE;
	localparam logic [7:0] OP_UNIQUE_ID_RD = 8'h4B;
	localparam logic [7:0] OP_INFO_ROW_RD = 8'h68;
	localparam logic [7:0] OP_SET_NV = 8'h85;
	localparam logic [7:0] OP_SET_V = 8'h83;
	localparam logic [7:0] OP_RD_EXT = 8'h81;
	localparam logic [7:0] OP_CLR_EXT = 8'h82;
	localparam logic [7:0] OP_SW_RST = 8'h99;

	////////////////////////////////////////////////////////////////
	// Default dummy cycles
	localparam logic [CNT_W-1:0] DUMMY_STD = 4'h8;
	localparam logic [CNT_W-1:0] DUMMY_QPI = 4'h6;
	localparam logic [CNT_W-1:0] DUMMY_DUAL_IO = 4'h4;
	localparam logic [CNT_W-1:0] DUMMY_QUAD_IO = 4'h6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

	////////////////////////////////////////////////////////////////
	// Drive strength codes and reset values
	localparam logic [DRV_W-1:0] DRV_RSV_A = 3'h0;
	localparam logic [DRV_W-1:0] DRV_90 = 3'h1;
	localparam logic [DRV_W-1:0] DRV_60 = 3'h2;
	localparam logic [DRV_W-1:0] DRV_45 = 3'h3;
	localparam logic [DRV_W-1:0] DRV_RSV_B = 3'h4;
	localparam logic [DRV_W-1:0] DRV_20 = 3'h5;
	localparam logic [DRV_W-1:0] DRV_15 = 3'h6;
	localparam logic [DRV_W-1:0] DRV_30 = 3'h7;
	localparam logic [DRV_W-1:0] DRV_DEFAULT = DRV_30;
	localparam logic LPE_DEFAULT = 1'b0;
	localparam logic [ERR_W-1:0] ERR_NONE = 3'h0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

	////////////////////////////////////////////////////////////////
	// Outcome report kinds
	typedef enum logic [3:0] {
		EV_PROG = 4'h0,
		EV_IROW_PROG = 4'h1,
		EV_PMODE = 4'h2,
		EV_UNLOCK = 4'h3,
		EV_NVREG = 4'h4,
		EV_SRWRITE = 4'h5,
		EV_FRWRITE = 4'h6,
		EV_ERASE = 4'h7,
		EV_CHIP_ERASE = 4'h8
	} fxr_ev_t;
endpackage

// ===== verilog/fxr_link_if.sv
// Command-level link between flash host and flash device.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ps
interface fxr_link_if;
	logic cmd_valid;
	logic [fxr_pkg::DATA_W-1:0] cmd_op;
	logic [fxr_pkg::DATA_W-1:0] cmd_data;
	logic cmd_qpi;
	logic host_oe;
	logic rsp_valid;
	logic [fxr_pkg::DATA_W-1:0] rsp_data;
	logic rsp_err;

	modport dev (
		input cmd_valid, cmd_op, cmd_data, cmd_qpi, host_oe,
		output rsp_valid, rsp_data, rsp_err
	);
	modport host (
		output cmd_valid, cmd_op, cmd_data, cmd_qpi, host_oe,
		input rsp_valid, rsp_data, rsp_err
	);
endinterface

// ===== verilog/fxr_dummy_lut.sv
// Default dummy-cycle lookup for the read commands.
// Assumes the caller holds op and mode stable while it reads the result.
`timescale 1ns/1ps
module fxr_dummy_lut (
	// Command
	input wire logic [fxr_pkg::DATA_W-1:0] op_i,
	input wire logic qpi_i,
	// Result
	output logic is_read_o,
	output logic legal_o,
	output logic [fxr_pkg::CNT_W-1:0] cnt_o
);
	import fxr_pkg::*;

	always_comb begin
		is_read_o = 1'b0;
		legal_o = 1'b0;
		cnt_o = CNT_ZERO;
		case (op_i)
			OP_FAST_RD, OP_FAST_RD4, OP_DTR_RD, OP_DTR_RD4,
			OP_UNIQUE_ID_RD, OP_INFO_ROW_RD: begin
				is_read_o = 1'b1;
				legal_o = 1'b1;
				cnt_o = qpi_i ? DUMMY_QPI : DUMMY_STD;
			end
			OP_DUAL_OUT, OP_DUAL_OUT4, OP_QUAD_OUT, OP_QUAD_OUT4: begin
				is_read_o = 1'b1;
				legal_o = !qpi_i;
				cnt_o = DUMMY_STD;
			end
			OP_DUAL_IO, OP_DUAL_IO4, OP_DUAL_IO_DTR, OP_DUAL_IO_DTR4: begin
				is_read_o = 1'b1;
				legal_o = !qpi_i;
				cnt_o = DUMMY_DUAL_IO;
			end
			OP_QUAD_IO, OP_QUAD_IO4, OP_QUAD_IO_DTR, OP_QUAD_IO_DTR4: begin
				is_read_o = 1'b1;
				legal_o = 1'b1;
				cnt_o = DUMMY_QUAD_IO;
			end
			default: begin
				is_read_o = 1'b0;
			end
		endcase
	end
endmodule

// ===== verilog/fxr_dev.sv
// Flash device end: extended read register, error flags, read dummy phase.
// Assumes the host sends one command at a time and waits for answers.
`timescale 1ns/1ps
module fxr_dev (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link to the host
	fxr_link_if.dev link,
	// Array side
	input wire logic busy_i,
	input wire logic [fxr_pkg::DATA_W-1:0] arr_data_i,
	// Operation outcome reports
	input wire logic ev_valid_i,
	input wire fxr_pkg::fxr_ev_t ev_kind_i,
	input wire logic ev_fail_i,
	input wire logic ev_prot_i,
	input wire logic ev_erase_fail_i,
	input wire logic ev_bp_cover_i,
	// Settings and state out
	output logic [fxr_pkg::DRV_W-1:0] drive_strength_o,
	output logic learn_pat_en_o,
	output logic nv_update_o,
	output logic [fxr_pkg::DATA_W-1:0] ext_reg_o
);
	import fxr_pkg::*;

	typedef enum logic [2:0] {
		D_IDLE = 3'h1,
		D_DUMMY = 3'h2,
		D_RESP = 3'h4
	} fxr_dstate_t;

	////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Reserved codes are refused so the pads never see an undefined drive
	function automatic logic drv_ok(logic [DRV_W-1:0] code);
		return (code != DRV_RSV_A) && (code != DRV_RSV_B);
	endfunction

	// Which error flags an outcome report raises; layout {E, P, prot}
	function automatic logic [ERR_W-1:0] err_set(fxr_ev_t kind, logic fail,
			logic prot, logic efail, logic bp);
		logic [ERR_W-1:0] s;
		s = ERR_NONE;
		case (kind)
			EV_PROG, EV_IROW_PROG, EV_PMODE: begin
				s[ERR_P] = fail | prot;
				s[ERR_X] = prot;
			end
			EV_UNLOCK: begin
				s[ERR_P] = prot;
				s[ERR_X] = prot;
			end
			EV_NVREG: begin
				s[ERR_P] = fail;
				s[ERR_E] = efail;
			end
			EV_SRWRITE: begin
				s[ERR_P] = fail;
				s[ERR_E] = efail | prot;
				s[ERR_X] = prot;
			end
			EV_FRWRITE: begin
				s[ERR_P] = fail;
			end
			EV_ERASE: begin
				s[ERR_E] = fail | prot;
				s[ERR_X] = prot;
			end
			EV_CHIP_ERASE: begin
				// Sector locks alone do not count here
				s[ERR_E] = fail | bp;
				s[ERR_X] = bp;
			end
			default: begin
				s = ERR_NONE;
			end
		endcase
		return s;
	endfunction

	////////////////////////////////////////////////////////////////
	// State

	fxr_dstate_t state_q;
	logic [DRV_W-1:0] nv_drv_q;
	logic nv_lpe_q;
	logic [DRV_W-1:0] drv_q;
	logic lpe_q;
	logic [ERR_W-1:0] err_q;
	logic [ERR_W-1:0] err_d;
	logic [CNT_W-1:0] cnt_q;
	logic [DATA_W-1:0] data_q;
	logic rsp_err_q;
	logic nv_upd_q;
	logic take;
	logic is_set_nv;
	logic is_set_v;
	logic is_clear;
	logic lut_read;
	logic lut_legal;
	logic [CNT_W-1:0] lut_cnt;
	logic [DATA_W-1:0] ext_val;
	logic [DRV_W-1:0] new_drv;
	logic new_lpe;

	fxr_dummy_lut u_lut (
		.op_i(link.cmd_op),
		.qpi_i(link.cmd_qpi),
		.is_read_o(lut_read),
		.legal_o(lut_legal),
		.cnt_o(lut_cnt)
	);

	////////////////////////////////////////////////////////////////
	// Command decode

	// Error flags do not gate acceptance
	assign take = link.cmd_valid && (state_q == D_IDLE);
	assign is_set_nv = take && (link.cmd_op == OP_SET_NV);
	assign is_set_v = take && (link.cmd_op == OP_SET_V);
	assign is_clear = take && ((link.cmd_op == OP_CLR_EXT) || (link.cmd_op == OP_SW_RST));
	// Only the high four data bits are looked at
	assign new_drv = link.cmd_data[EXT_DRV_HI:EXT_DRV_LO];
	assign new_lpe = link.cmd_data[EXT_LPE];

	////////////////////////////////////////////////////////////////
	// Register image

	assign ext_val = {drv_q, lpe_q, err_q, busy_i};
	assign ext_reg_o = ext_val;
	assign drive_strength_o = drv_q;
	assign learn_pat_en_o = lpe_q;
	assign nv_update_o = nv_upd_q;

	////////////////////////////////////////////////////////////////
	// Non-volatile copy

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nv_drv_q <= DRV_DEFAULT;
			nv_lpe_q <= LPE_DEFAULT;
		end else if (is_set_nv) begin
			if (drv_ok(new_drv)) begin
				nv_drv_q <= new_drv;
			end
			nv_lpe_q <= new_lpe;
		end
	end

	// Kicks off the internal erase-then-program of the stored copy
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nv_upd_q <= 1'b0;
		end else begin
			nv_upd_q <= is_set_nv;
		end
	end

	////////////////////////////////////////////////////////////////
	// Volatile copy

	// Software reset reloads the working copy from the stored one
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			drv_q <= DRV_DEFAULT;
			lpe_q <= LPE_DEFAULT;
		end else if (is_set_v) begin
			if (drv_ok(new_drv)) begin
				drv_q <= new_drv;
			end
			lpe_q <= new_lpe;
		end else if (take && (link.cmd_op == OP_SW_RST)) begin
			drv_q <= nv_drv_q;
			lpe_q <= nv_lpe_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sticky error flags

	// A report in the clearing cycle survives: set wins over clear
	always_comb begin
		err_d = is_clear ? ERR_NONE : err_q;
		if (ev_valid_i) begin
			err_d = err_d | err_set(ev_kind_i, ev_fail_i, ev_prot_i,
				ev_erase_fail_i, ev_bp_cover_i);
		end
	end

	// Set commands never reach these bits
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			err_q <= ERR_NONE;
		end else begin
			err_q <= err_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read answer sequencer

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= D_IDLE;
			cnt_q <= CNT_ZERO;
			data_q <= DATA_ZERO;
			rsp_err_q <= 1'b0;
		end else begin
			case (state_q)
				D_IDLE: begin
					if (take && lut_read) begin
						if (lut_legal) begin
							state_q <= D_DUMMY;
							cnt_q <= lut_cnt - CNT_ONE;
							rsp_err_q <= 1'b0;
						end else begin
							// Mode-restricted read in the wrong mode
							state_q <= D_RESP;
							data_q <= DATA_ZERO;
							rsp_err_q <= 1'b1;
						end
					end else if (take && (link.cmd_op == OP_RD_EXT)) begin
						state_q <= D_RESP;
						data_q <= ext_val;
						rsp_err_q <= 1'b0;
					end
				end
				D_DUMMY: begin
					// Host has released the lines here
					if (cnt_q == CNT_ZERO) begin
						state_q <= D_RESP;
						data_q <= arr_data_i;
					end else begin
						cnt_q <= cnt_q - CNT_ONE;
					end
				end
				D_RESP: begin
					state_q <= D_IDLE;
				end
				default: begin
					state_q <= D_IDLE;
				end
			endcase
		end
	end

	assign link.rsp_valid = (state_q == D_RESP);
	assign link.rsp_data = data_q;
	assign link.rsp_err = rsp_err_q;
endmodule

// ===== verilog/fxr_host.sv
// Flash host end: issues one command, floats during dummy, collects answer.
// Assumes the device answers every read within its dummy count plus two.
`timescale 1ns/1ps
module fxr_host (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link to the device
	fxr_link_if.host link,
	// User requests
	input wire logic req_valid_i,
	input wire logic [fxr_pkg::DATA_W-1:0] req_op_i,
	input wire logic [fxr_pkg::DATA_W-1:0] req_data_i,
	input wire logic qpi_i,
	output logic req_ready_o,
	// User answers
	output logic rsp_valid_o,
	output logic [fxr_pkg::DATA_W-1:0] rsp_data_o,
	output logic rsp_err_o,
	output logic [fxr_pkg::CNT_W-1:0] dummy_o
);
	import fxr_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE = 3'h1,
		H_CMD = 3'h2,
		H_WAIT = 3'h4
	} fxr_hstate_t;

	fxr_hstate_t state_q;
	logic [DATA_W-1:0] op_q;
	logic [DATA_W-1:0] data_q;
	logic qpi_q;
	logic wait_q;
	logic [CNT_W-1:0] dummy_q;
	logic rsp_vld_q;
	logic [DATA_W-1:0] rsp_data_q;
	logic rsp_err_q;
	logic lut_read;
	logic lut_legal;
	logic [CNT_W-1:0] lut_cnt;

	fxr_dummy_lut u_lut (
		.op_i(req_op_i),
		.qpi_i(qpi_i),
		.is_read_o(lut_read),
		.legal_o(lut_legal),
		.cnt_o(lut_cnt)
	);

	////////////////////////////////////////////////////////////////
	// Link drive

	assign req_ready_o = (state_q == H_IDLE);
	assign link.cmd_valid = (state_q == H_CMD);
	// Lines released outside the command beat, so no clash in dummy
	assign link.host_oe = (state_q == H_CMD);
	assign link.cmd_op = op_q;
	assign link.cmd_data = data_q;
	assign link.cmd_qpi = qpi_q;
	assign rsp_valid_o = rsp_vld_q;
	assign rsp_data_o = rsp_data_q;
	assign rsp_err_o = rsp_err_q;
	assign dummy_o = dummy_q;

	////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= H_IDLE;
			op_q <= DATA_ZERO;
			data_q <= DATA_ZERO;
			qpi_q <= 1'b0;
			wait_q <= 1'b0;
			dummy_q <= CNT_ZERO;
			rsp_vld_q <= 1'b0;
			rsp_data_q <= DATA_ZERO;
			rsp_err_q <= 1'b0;
		end else begin
			rsp_vld_q <= 1'b0;
			case (state_q)
				H_IDLE: begin
					if (req_valid_i && lut_read && !lut_legal) begin
						// Refused locally: no QPI form exists
						rsp_vld_q <= 1'b1;
						rsp_err_q <= 1'b1;
						rsp_data_q <= DATA_ZERO;
					end else if (req_valid_i) begin
						state_q <= H_CMD;
						op_q <= req_op_i;
						data_q <= req_data_i;
						qpi_q <= qpi_i;
						wait_q <= lut_read || (req_op_i == OP_RD_EXT);
						dummy_q <= lut_cnt;
					end
				end
				H_CMD: begin
					state_q <= wait_q ? H_WAIT : H_IDLE;
				end
				H_WAIT: begin
					if (link.rsp_valid) begin
						state_q <= H_IDLE;
						rsp_vld_q <= 1'b1;
						rsp_data_q <= link.rsp_data;
						rsp_err_q <= link.rsp_err;
					end
				end
				default: begin
					state_q <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== testbench/fxr_link_asserts.sv
// Link checker for the extended read register block.
// Assumes it sits beside the link interface, fed its signals by name.
`timescale 1ns/1ps
module fxr_link_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link signals
	input wire logic cmd_valid,
	input wire logic [fxr_pkg::DATA_W-1:0] cmd_op,
	input wire logic [fxr_pkg::DATA_W-1:0] cmd_data,
	input wire logic cmd_qpi,
	input wire logic host_oe,
	input wire logic rsp_valid,
	input wire logic [fxr_pkg::DATA_W-1:0] rsp_data,
	input wire logic rsp_err
);
	import fxr_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	// Read classes by default dummy count, plus refused QPI reads and set commands
	logic fast_rd, spi8, six, io4, qbad, setop;
	assign fast_rd = cmd_op inside {8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68};
	assign spi8 = cmd_valid && !cmd_qpi && (fast_rd || cmd_op inside {8'h3B, 8'h3C, 8'h6B, 8'h6C});
	assign six = cmd_valid && (cmd_qpi && fast_rd || cmd_op inside {8'hEB, 8'hEC, 8'hED, 8'hEE});
	assign io4 = cmd_valid && !cmd_qpi && cmd_op inside {8'hBB, 8'hBC, 8'hBD, 8'hBE};
	assign qbad = cmd_valid && cmd_qpi && cmd_op inside {8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB, 8'hBC,
		8'hBD, 8'hBE};
	assign setop = cmd_valid && cmd_op inside {OP_SET_NV, OP_SET_V, OP_CLR_EXT, OP_SW_RST};
	////////////////////////////////////////////////////////////////
	// Assertions
	a_oe_follows_cmd: assert property (host_oe == cmd_valid)
		else $error("host drives data lines outside the command cycle");
	a_cmd_single_cycle: assert property (cmd_valid |=> !cmd_valid)
		else $error("command held longer than one cycle");
	a_eight_dummy: assert property (spi8 |=> !rsp_valid [*8] ##1 (rsp_valid && !rsp_err))
		else $error("read answer not after eight dummy cycles");
	a_six_dummy: assert property (six |=> !rsp_valid [*6] ##1 (rsp_valid && !rsp_err))
		else $error("read answer not after six dummy cycles");
	a_four_dummy: assert property (io4 |=> !rsp_valid [*4] ##1 (rsp_valid && !rsp_err))
		else $error("dual io answer not after four dummy cycles");
	a_qpi_refused: assert property (!qbad)
		else $error("spi only read sent in qpi mode");
	a_reg_answer: assert property (cmd_valid && cmd_op == OP_RD_EXT |=> rsp_valid && !rsp_err)
		else $error("register read not answered next cycle");
	a_set_quiet: assert property (setop |=> !rsp_valid [*2])
		else $error("set command produced an answer");
	c_eight: cover property (spi8);
	c_six: cover property (six);
	c_four: cover property (io4);
	c_set_nv: cover property (cmd_valid && cmd_op == OP_SET_NV);
endmodule

// ===== testbench/flash_ext_read_reg_errors_tb_top.sv
// Bench joining host and device ends, with a reference model of the register.
// Assumes one 100 MHz clock; the bench also plays the array engine.
`timescale 1ns/1ps
module flash_ext_read_reg_errors_tb_top;
	import fxr_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid = 1'b0, qpi = 1'b0, busy = 1'b0;
	logic evv = 1'b0, evf = 1'b0, evp = 1'b0, eve = 1'b0, evb = 1'b0;
	logic [7:0] req_op = 8'h00, req_data = 8'h00, arr = 8'h00;
	fxr_ev_t evk = EV_PROG;
	logic ready, rv, re, lpe_o, nvu;
	logic [7:0] rd, img;
	logic [3:0] dn;
	logic [2:0] drv_o;
	int errors = 0, cmp_count = 0;
	int drv, lpe, nvd, nvl, e, p, x, i, j;
	logic [7:0] ops [18] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68, 8'h3B, 8'h3C, 8'h6B, 8'h6C,
		8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hEB, 8'hEC, 8'hED, 8'hEE};
	always #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	fxr_link_if u_fxr_link_if ();
	fxr_dev u_fxr_dev (.clk_i(clk_i), .rst_i(rst_i), .link(u_fxr_link_if.dev), .busy_i(busy),
		.arr_data_i(arr), .ev_valid_i(evv), .ev_kind_i(evk), .ev_fail_i(evf), .ev_prot_i(evp),
		.ev_erase_fail_i(eve), .ev_bp_cover_i(evb), .drive_strength_o(drv_o),
		.learn_pat_en_o(lpe_o), .nv_update_o(nvu), .ext_reg_o(img));
	fxr_host u_fxr_host (.clk_i(clk_i), .rst_i(rst_i), .link(u_fxr_link_if.host),
		.req_valid_i(req_valid), .req_op_i(req_op), .req_data_i(req_data), .qpi_i(qpi),
		.req_ready_o(ready), .rsp_valid_o(rv), .rsp_data_o(rd), .rsp_err_o(re), .dummy_o(dn));
	fxr_link_asserts u_fxr_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
		.cmd_valid(u_fxr_link_if.cmd_valid), .cmd_op(u_fxr_link_if.cmd_op),
		.cmd_data(u_fxr_link_if.cmd_data), .cmd_qpi(u_fxr_link_if.cmd_qpi),
		.host_oe(u_fxr_link_if.host_oe), .rsp_valid(u_fxr_link_if.rsp_valid),
		.rsp_data(u_fxr_link_if.rsp_data), .rsp_err(u_fxr_link_if.rsp_err));
	////////////////////////////////////////////////////////////////
	// Model and helpers
	task automatic results();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] ex, input logic [7:0] got);
		cmp_count++;
		if (got !== ex) begin
			errors++;
			$display("unexpected at %0t: exp %h got %h", $time, ex, got);
		end
	endtask
	function automatic logic [7:0] image();
		return {drv[2:0], lpe[0], e[0], p[0], x[0], busy};
	endfunction
	function automatic int exp_n(input logic [7:0] op, input logic q);
		case (op)
			8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h4B, 8'h68: return q ? 6 : 8;
			8'h3B, 8'h3C, 8'h6B, 8'h6C: return q ? -1 : 8;
			8'hBB, 8'hBC, 8'hBD, 8'hBE: return q ? -1 : 4;
			default: return 6;
		endcase
	endfunction
	task automatic reset_model();
		drv = 7;
		lpe = 0;
		nvd = 7;
		nvl = 0;
		e = 0;
		p = 0;
		x = 0;
	endtask
	// Entered and left at a falling edge, so inputs never move on the sampling edge
	task automatic go(input logic [7:0] op, input logic [7:0] d, input logic q);
		int n;
		n = 0;
		// One edge between calls, so req_valid never drops and rises in one step
		@(negedge clk_i);
		while (ready !== 1'b1 && n < 50) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 50) begin
			errors++;
			results();
		end
		req_valid = 1'b1;
		req_op = op;
		req_data = d;
		qpi = q;
		@(negedge clk_i);
		req_valid = 1'b0;
	endtask
	// n is the dummy count, -1 for a refused read; register read passes 0
	task automatic rd_op(input logic [7:0] op, input logic q, input int n);
		int k;
		arr = 8'($urandom);
		go(op, 8'h00, q);
		k = 1;
		while (rv !== 1'b1 && k < 40) begin
			@(negedge clk_i);
			k++;
		end
		// Take, command beat, n dummy beats, device answer, host answer
		chk(8'(n < 0 ? 1 : n + 3), 8'(k));
		if (k == 40) results();
		chk(8'(n < 0), 8'(re));
		if (n >= 0) chk(op == OP_RD_EXT ? image() : arr, rd);
		if (n >= 0 && op != OP_RD_EXT) chk(8'(n), 8'(dn));
	endtask
	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		go(op, d, 1'b0);
		// Reserved drive codes leave the field as it was
		if (op == OP_SET_V && d[7:5] != 3'h0 && d[7:5] != 3'h4) drv = d[7:5];
		if (op == OP_SET_V) lpe = d[4];
		if (op == OP_SET_NV && d[7:5] != 3'h0 && d[7:5] != 3'h4) nvd = d[7:5];
		if (op == OP_SET_NV) nvl = d[4];
		if (op == OP_CLR_EXT || op == OP_SW_RST) {e, p, x} = '0;
		if (op == OP_SW_RST) {drv, lpe} = {nvd, nvl};
		@(negedge clk_i);
		chk(8'(op == OP_SET_NV), 8'(nvu));
		chk(8'(drv), 8'(drv_o));
		chk(8'(lpe), 8'(lpe_o));
		chk(image(), img);
	endtask
	task automatic ev();
		// Let an edge pass so back-to-back reports do not rewrite evv in one step
		@(negedge clk_i);
		evk = fxr_ev_t'($urandom_range(8));
		evf = 1'($urandom_range(1));
		evp = 1'($urandom_range(1));
		eve = 1'($urandom_range(1));
		evb = 1'($urandom_range(1));
		evv = 1'b1;
		@(negedge clk_i);
		evv = 1'b0;
		case (evk)
			EV_UNLOCK: begin p |= evp; x |= evp; end
			EV_NVREG: begin p |= evf; e |= eve; end
			EV_SRWRITE: begin p |= evf; e |= eve | evp; x |= evp; end
			EV_FRWRITE: p |= evf;
			EV_ERASE: begin e |= evf | evp; x |= evp; end
			EV_CHIP_ERASE: begin e |= evf | evb; x |= evb; end
			default: begin p |= evf | evp; x |= evp; end
		endcase
		chk(image(), img);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(31));
		reset_model();
		repeat (16) @(negedge clk_i);
		rst_i = 1'b0;
		chk(image(), img);
		busy = 1'b1;
		rd_op(OP_RD_EXT, 1'b0, 0);
		busy = 1'b0;
		for (i = 0; i < 18; i++) begin
			for (j = 0; j < 2; j++) rd_op(ops[i], 1'(j), exp_n(ops[i], 1'(j)));
		end
		for (i = 0; i < 8; i++) wr(OP_SET_V, {3'(i), 5'($urandom)});
		wr(OP_SET_NV, 8'h5F);
		repeat (30) ev();
		rd_op(OP_QUAD_IO, 1'b1, 6);
		rd_op(OP_RD_EXT, 1'b0, 0);
		wr(OP_CLR_EXT, 8'h00);
		repeat (5) ev();
		wr(OP_SW_RST, 8'h00);
		repeat (3) ev();
		rst_i = 1'b1;
		reset_model();
		@(negedge clk_i);
		rst_i = 1'b0;
		chk(image(), img);
		wr(OP_SW_RST, 8'h00);
		results();
	end
endmodule
